// [sim/input_capture_counter_regs_bench.sv]
// Self-checking bench for the input capture counter register block
`timescale 1ns/1ps
`default_nettype none
module input_capture_counter_regs_bench import icc_pkg::*; ;
    logic aclk;
    logic aresetn;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] edges;
    int n_fail = 0;
    int check_count = 0;

    icc_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .edge_input_0(edges[0]),
        .edge_input_1(edges[1]), .edge_input_2(edges[2]), .irq(irq));

    // 250 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // Verdict and end of run, shared by the tests and the watchdog
    task automatic wrap_up();
        $display("Checks: %0d, mismatches: %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Shared comparison; case inequality so an unknown never matches
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask

    // A handshake that never comes counts as a mismatch
    task automatic guard(input int k);
        if (k >= 100) begin
            n_fail++;
            $display("Error at %0t ns: bus handshake stalled", $time);
        end
    endtask

    // AXI4-Lite write; address and data released each at its own handshake
    task automatic axi_write(input logic [7:0] addr, input logic [31:0] data, input logic [3:0] strb,
                             input logic [1:0] exp_resp);
        int k;
        logic aw_ok;
        logic w_ok;
        k = 0;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= addr;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= data;
        s_axi_wstrb <= strb;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok) && k < 100) begin
            @(posedge aclk);
            k++;
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        // Response is taken at the edge where bvalid is seen with bready high
        do begin
            @(posedge aclk);
            k++;
        end while (s_axi_bvalid !== 1'b1 && k < 100);
        s_axi_bready <= 1'b0;
        guard(k);
        chk({30'h0, s_axi_bresp}, {30'h0, exp_resp});
    endtask

    // AXI4-Lite read; data taken at the rvalid and rready edge
    task automatic axi_read(input logic [7:0] addr, output logic [31:0] data, input logic [1:0] exp_resp);
        int k;
        k = 0;
        @(posedge aclk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= addr;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
        end while (s_axi_arready !== 1'b1 && k < 100);
        s_axi_arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            k++;
        end while (s_axi_rvalid !== 1'b1 && k < 100);
        data = s_axi_rdata;
        s_axi_rready <= 1'b0;
        guard(k);
        chk({30'h0, s_axi_rresp}, {30'h0, exp_resp});
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        axi_read(addr, d, RESP_OKAY);
        chk(d, exp);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        axi_write(addr, data, 4'hF, RESP_OKAY);
    endtask

    // Rising edge on one capture input, low before and after
    task automatic pulse(input int n);
        @(posedge aclk);
        edges[n] <= 1'b1;
        repeat (3) @(posedge aclk);
        edges[n] <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask

    // Runs the counter for a span with the given control value, then stops it
    task automatic run_for(input logic [31:0] ctrl, input int cycles);
        wr(OFF_CTRL, ctrl);
        repeat (cycles) @(posedge aclk);
        wr(OFF_CTRL, 32'h0000_0000);
    endtask

    // Watchdog: the tests need under a thousand cycles
    initial begin
        #100000;
        n_fail++;
        $display("Error at %0t ns: watchdog expired", $time);
        wrap_up();
    end

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'h0;
        edges = 3'h0;
        aresetn = 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values of the data registers, then an unmapped place
        for (int i = 0; i < 5; i++) begin
            rd_chk(8'(4 * i), 32'h0000_0000);
        end
        axi_read(8'hFC, v, RESP_SLVERR);
        chk(v, 32'h0000_0000);
        axi_write(8'hFC, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
        // Upper byte reads zero; stopped counter keeps its value
        wr(OFF_CNT, 32'hFFFF_FFFF);
        rd_chk(OFF_CNT, 32'h00FF_FFFF);
        repeat (20) @(posedge aclk);
        rd_chk(OFF_CNT, 32'h00FF_FFFF);
        // Hold registers are writable, byte lanes honoured
        axi_write(OFF_HOLD0, 32'hFFFF_FFAB, 4'h1, RESP_OKAY);
        rd_chk(OFF_HOLD0, 32'h0000_00AB);
        wr(OFF_HOLD0 + HOLD_STEP, 32'hFFFF_FFFF);
        rd_chk(OFF_HOLD0 + HOLD_STEP, 32'h00FF_FFFF);
        wr(OFF_HOLD0 + 8'h08, 32'h00A5_5A5A);
        // Running from the maximum wraps and raises the overflow flag
        run_for(32'h0000_0001, 20);
        axi_read(OFF_CNT, v, RESP_OKAY);
        chk({31'h0, v > 32'h0 && v < 32'h40}, 32'h1);
        rd_chk(OFF_STAT, 32'h0000_0020);
        repeat (10) @(posedge aclk);
        rd_chk(OFF_STAT, 32'h0000_0020);
        wr(OFF_STAT, 32'h0000_0020);
        rd_chk(OFF_STAT, 32'h0000_0000);
        // Divide by 128: about 304 cycles give two or three ticks
        wr(OFF_CNT, 32'h0000_0000);
        run_for(32'h0000_7001, 300);
        axi_read(OFF_CNT, v, RESP_OKAY);
        chk({31'h0, v >= 32'h2 && v <= 32'h3}, 32'h1);
        // Divide by 4: 44 running cycles give about eleven ticks
        wr(OFF_CNT, 32'h0000_0000);
        run_for(32'h0000_1001, 40);
        axi_read(OFF_CNT, v, RESP_OKAY);
        chk({31'h0, v >= 32'hA && v <= 32'hC}, 32'h1);
        // Passing the compare value sets the match flag only in compare mode
        wr(OFF_CMP, 32'h0000_0010);
        wr(OFF_CNT, 32'h0000_0000);
        run_for(32'h0000_0001, 40);
        rd_chk(OFF_STAT, 32'h0000_0000);
        wr(OFF_CNT, 32'h0000_0000);
        run_for(32'h0000_0003, 40);
        rd_chk(OFF_STAT, 32'h0000_0010);
        axi_read(OFF_CNT, v, RESP_OKAY);
        chk({31'h0, v > 32'h10}, 32'h1);
        wr(OFF_ICLR, 32'h0000_0010);
        // Clear on match keeps the counter below the compare value
        wr(OFF_CNT, 32'h0000_0000);
        run_for(32'h0000_0013, 40);
        axi_read(OFF_CNT, v, RESP_OKAY);
        chk({31'h0, v < 32'h10}, 32'h1);
        rd_chk(OFF_STAT, 32'h0000_0010);
        wr(OFF_ICLR, 32'h0000_0010);
        // Capture on channel 1 while stopped; other holds untouched
        wr(OFF_CTRL, 32'h0000_00E0);
        wr(OFF_CNT, 32'h0000_1234);
        wr(OFF_IEN, 32'h0000_0002);
        pulse(1);
        rd_chk(OFF_HOLD0 + HOLD_STEP, 32'h0000_1234);
        rd_chk(OFF_HOLD0, 32'h0000_00AB);
        rd_chk(OFF_HOLD0 + 8'h08, 32'h00A5_5A5A);
        rd_chk(OFF_STAT, 32'h0000_0002);
        chk({31'h0, irq}, 32'h1);
        // Masking and clearing the interrupt
        wr(OFF_IEN, 32'h0000_0000);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        wr(OFF_IEN, 32'h0000_0002);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        wr(OFF_ICLR, 32'h0000_0002);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        rd_chk(OFF_STAT, 32'h0000_0000);
        // Disabled channel 2 captures nothing
        wr(OFF_CTRL, 32'h0000_0060);
        pulse(2);
        rd_chk(OFF_HOLD0 + 8'h08, 32'h00A5_5A5A);
        rd_chk(OFF_STAT, 32'h0000_0000);
        // Reload plus clear on a channel 0 event: only the reload happens;
        // an unselected channel 1 event then must not clear either
        wr(OFF_CMP, 32'h0000_0123);
        wr(OFF_CNT, 32'h0000_0055);
        wr(OFF_CTRL, 32'h0000_026C);
        pulse(0);
        rd_chk(OFF_CNT, 32'h0000_0123);
        rd_chk(OFF_HOLD0, 32'h0000_0055);
        pulse(1);
        rd_chk(OFF_CNT, 32'h0000_0123);
        rd_chk(OFF_HOLD0 + HOLD_STEP, 32'h0000_0123);
        // Clear on edge alone zeroes the counter
        wr(OFF_CNT, 32'h0000_0077);
        wr(OFF_CTRL, 32'h0000_0088);
        pulse(2);
        rd_chk(OFF_CNT, 32'h0000_0000);
        rd_chk(OFF_HOLD0 + 8'h08, 32'h0000_0077);
        // Overflow reloads the compare/reload value
        wr(OFF_CMP, 32'h0000_1000);
        wr(OFF_CNT, 32'h00FF_FFF8);
        run_for(32'h0000_0105, 20);
        axi_read(OFF_CNT, v, RESP_OKAY);
        chk({31'h0, v > 32'h1000 && v < 32'h1040}, 32'h1);
        rd_chk(OFF_STAT, 32'h0000_0027);
        wrap_up();
    end
endmodule
`default_nettype wire

// [src/icc_pkg.sv]
// Constants, register map and field layout of the input capture counter block
// Functional notes
// - Capture counter is 24 bits wide in bits 23:0; bits 31:24 read zero.
// - Counter advances only on divided capture clock ticks, never on raw clock.
// - A valid edge on an enabled channel copies the counter into its hold.
// - Three hold registers, each loaded only by the input of the same index or by a software write.
// - With compare mode on, counter is compared against compare/reload value.
// - With reload mode on, an overflow or edge event selected by the reload select bits reloads the counter.
// - With compare mode on, match flag sets when the counting counter reaches the compare value.
// - Counter does not count while run bit is 0 (write, reload and edge clear still apply), counts on ticks while it is 1.
// - With both clear-on-edge and reload on, an edge event never clears; only an edge selected by the reload select bits reloads.
// - Event flags set by hardware stay set; writing 1 clears them.
`default_nettype none
package icc_pkg;
    localparam int CNT_W = 24;
    localparam int NCH = 3;
    localparam int ADDR_W = 8;
    localparam int DIV_W = 7;
    // Register byte offsets
    localparam logic [7:0] OFF_CNT = 8'h00;
    localparam logic [7:0] OFF_HOLD0 = 8'h04;
    localparam logic [7:0] OFF_CMP = 8'h10;
    localparam logic [7:0] OFF_CTRL = 8'h14;
    localparam logic [7:0] OFF_STAT = 8'h18;
    localparam logic [7:0] OFF_IEN = 8'h1C;
    localparam logic [7:0] OFF_ICLR = 8'h20;
    localparam logic [7:0] HOLD_STEP = 8'h04;
    // Control register fields
    localparam int CTL_RUN = 0;
    localparam int CTL_CMP = 1;
    localparam int CTL_RLD = 2;
    localparam int CTL_CLRE = 3;
    localparam int CTL_CLRM = 4;
    localparam int CTL_CHEN = 5;
    localparam int CTL_RSEL = 8;
    localparam int CTL_DIV = 12;
    localparam int CTRL_W = 15;
    // Status, enable and clear layout
    localparam int ST_EDGE = 0;
    localparam int ST_MATCH = 4;
    localparam int ST_OVF = 5;
    localparam int FLAG_W = 6;
    localparam logic [5:0] FLAG_MASK = 6'h37;
    // Reset values and limits
    localparam logic [23:0] CNT_RST = 24'h00_0000;
    localparam logic [23:0] CNT_MAX = 24'hFF_FFFF;
    localparam logic [23:0] CNT_ONE = 24'h00_0001;
    localparam logic [14:0] CTRL_RST = 15'h0000;
    localparam logic [5:0] FLAG_RST = 6'h00;
    localparam logic [6:0] DIV_RST = 7'h00;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// [src/icc_tick_div.sv]
// Capture clock divider: one tick every 1,4,16,32,64,96,112 or 128 cycles
`timescale 1ns/1ps
`default_nettype none
module icc_tick_div (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Tick towards the counter
    icc_tick_if.gen tk
);
    import icc_pkg::*;

    logic [DIV_W-1:0] div_cnt_ff;
    logic [DIV_W-1:0] nxt_div_cnt;
    logic [DIV_W-1:0] last;

    // Terminal count for each divide setting
    function automatic logic [DIV_W-1:0] div_last(input logic [2:0] s);
        unique case (s)
            3'h0: div_last = 7'h00;
            3'h1: div_last = 7'h03;
            3'h2: div_last = 7'h0F;
            3'h3: div_last = 7'h1F;
            3'h4: div_last = 7'h3F;
            3'h5: div_last = 7'h5F;
            3'h6: div_last = 7'h6F;
            3'h7: div_last = 7'h7F;
        endcase
    endfunction

    // Greater-or-equal so a smaller setting taken mid-period ends it at once
    always_comb begin
        last = div_last(tk.div_sel);
        tk.tick = (div_cnt_ff >= last);
        nxt_div_cnt = tk.tick ? DIV_RST : div_cnt_ff + 7'h01;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt_ff <= DIV_RST;
        end else begin
            div_cnt_ff <= nxt_div_cnt;
        end
    end
endmodule
`default_nettype wire

// [src/icc_tick_if.sv]
// Tick carrier between the clock divider and the counter core
`timescale 1ns/1ps
`default_nettype none
interface icc_tick_if;
    logic [2:0] div_sel;
    logic tick;
    modport gen(input div_sel, output tick);
    modport sink(output div_sel, input tick);
endinterface
`default_nettype wire

// [src/icc_top.sv]
// Input capture counter core with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module icc_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [icc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [icc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Capture inputs, synchronous to aclk
    input wire logic edge_input_0,
    input wire logic edge_input_1,
    input wire logic edge_input_2,
    // Interrupt
    output logic irq
);
    import icc_pkg::*;

    // All checks run on the bus clock and sleep through reset
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Bus slave state
    logic aw_got_ff;
    logic w_got_ff;
    logic [ADDR_W-1:0] waddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic do_wr;
    logic [31:0] rd_val;
    logic rd_ok;
    logic wr_ok;

    // Block state
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [CNT_W-1:0] cmp_ff;
    logic [CNT_W-1:0] hold_ff [NCH];
    logic [CTRL_W-1:0] ctrl_ff;
    logic [FLAG_W-1:0] flag_ff;
    logic [FLAG_W-1:0] ien_ff;
    logic [NCH-1:0] in_q_ff;
    logic irq_ff;

    // Decoded controls and events
    logic run;
    logic cmp_en;
    logic rld_en;
    logic clr_edge_en;
    logic clr_match_en;
    logic [NCH-1:0] ch_en;
    logic [3:0] rld_sel;
    logic [NCH-1:0] in_now;
    logic [NCH-1:0] cap_evt;
    logic inc;
    logic ovf_evt;
    logic match_evt;
    logic reload_evt;
    logic clear_edge;
    logic clear_match;
    logic wr_cnt;
    logic [FLAG_W-1:0] flag_set;
    logic [FLAG_W-1:0] flag_clr;

    icc_tick_if tk ();

    icc_tick_div u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .tk(tk)
    );

    // Byte-lane merge of a write into an existing word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Word-aligned register decode, shared by both directions
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        return {a[ADDR_W-1:2], 2'b00} == off;
    endfunction

    // Control field decode
    assign run = ctrl_ff[CTL_RUN];
    assign cmp_en = ctrl_ff[CTL_CMP];
    assign rld_en = ctrl_ff[CTL_RLD];
    assign clr_edge_en = ctrl_ff[CTL_CLRE];
    assign clr_match_en = ctrl_ff[CTL_CLRM];
    assign ch_en = ctrl_ff[CTL_CHEN +: NCH];
    assign rld_sel = ctrl_ff[CTL_RSEL +: 4];
    assign tk.div_sel = ctrl_ff[CTL_DIV +: 3];
    assign in_now = {edge_input_2, edge_input_1, edge_input_0};

    // Write channel accepts address and data in either order
    assign s_axi_awready = !aw_got_ff && !bvalid_ff;
    assign s_axi_wready = !w_got_ff && !bvalid_ff;
    assign do_wr = aw_got_ff && w_got_ff && !bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            waddr_ff <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff <= 1'b1;
            waddr_ff <= s_axi_awaddr;
        end else if (do_wr) begin
            aw_got_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_ff <= 1'b0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end else if (do_wr) begin
            w_got_ff <= 1'b0;
        end
    end

    // Response is raised by the same edge that performs the write
    assign wr_ok = hit(waddr_ff, OFF_CNT) || hit(waddr_ff, OFF_CMP) || hit(waddr_ff, OFF_CTRL)
                || hit(waddr_ff, OFF_STAT) || hit(waddr_ff, OFF_IEN) || hit(waddr_ff, OFF_ICLR)
                || hit(waddr_ff, OFF_HOLD0) || hit(waddr_ff, OFF_HOLD0 + HOLD_STEP)
                || hit(waddr_ff, OFF_HOLD0 + 8'h02 * HOLD_STEP);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (do_wr) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Read mux; the clear register reads as zero
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b1;
        if (hit(s_axi_araddr, OFF_CNT)) begin
            rd_val = {8'h00, cnt_ff};
        end else if (hit(s_axi_araddr, OFF_HOLD0)) begin
            rd_val = {8'h00, hold_ff[0]};
        end else if (hit(s_axi_araddr, OFF_HOLD0 + HOLD_STEP)) begin
            rd_val = {8'h00, hold_ff[1]};
        end else if (hit(s_axi_araddr, OFF_HOLD0 + 8'h02 * HOLD_STEP)) begin
            rd_val = {8'h00, hold_ff[2]};
        end else if (hit(s_axi_araddr, OFF_CMP)) begin
            rd_val = {8'h00, cmp_ff};
        end else if (hit(s_axi_araddr, OFF_CTRL)) begin
            rd_val = {17'h0_0000, ctrl_ff};
        end else if (hit(s_axi_araddr, OFF_STAT)) begin
            rd_val = {26'h000_0000, flag_ff};
        end else if (hit(s_axi_araddr, OFF_IEN)) begin
            rd_val = {26'h000_0000, ien_ff};
        end else if (!hit(s_axi_araddr, OFF_ICLR)) begin
            rd_ok = 1'b0;
        end
    end

    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // Read data is captured at the address edge and held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_ok ? rd_val : 32'h0000_0000;
            rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Rising edge detect on enabled channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_q_ff <= '0;
        end else begin
            in_q_ff <= in_now;
        end
    end

    assign cap_evt = ch_en & in_now & ~in_q_ff;

    // Counter events
    assign inc = run && tk.tick;
    assign ovf_evt = inc && (cnt_ff == CNT_MAX);
    assign match_evt = cmp_en && inc && (cnt_ff + CNT_ONE == cmp_ff);
    assign reload_evt = rld_en && ((rld_sel[0] && ovf_evt) || |(rld_sel[3:1] & cap_evt));
    assign clear_edge = clr_edge_en && |cap_evt && !rld_en;
    assign clear_match = clr_match_en && match_evt;
    assign wr_cnt = do_wr && hit(waddr_ff, OFF_CNT);

    // Software write wins, then reload, then clear, then count; wrap is natural
    always_comb begin
        nxt_cnt = cnt_ff;
        if (wr_cnt) begin
            nxt_cnt = CNT_W'(merge({8'h00, cnt_ff}, wdata_ff, wstrb_ff));
        end else if (reload_evt) begin
            nxt_cnt = cmp_ff;
        end else if (clear_edge || clear_match) begin
            nxt_cnt = CNT_RST;
        end else if (inc) begin
            nxt_cnt = cnt_ff + CNT_ONE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= CNT_RST;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // Hold registers; a capture beats a software write in the same cycle
    for (genvar i = 0; i < NCH; i++) begin : g_hold
        logic wr_hold;
        assign wr_hold = do_wr && hit(waddr_ff, OFF_HOLD0 + 8'(i) * HOLD_STEP);
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                hold_ff[i] <= CNT_RST;
            end else if (cap_evt[i]) begin
                hold_ff[i] <= cnt_ff;
            end else if (wr_hold) begin
                hold_ff[i] <= CNT_W'(merge({8'h00, hold_ff[i]}, wdata_ff, wstrb_ff));
            end
        end
        a_hold_capture: assert property (cap_evt[i] |=> hold_ff[i] == $past(cnt_ff))
            else $error("hold did not take the counter value");
        a_hold_other: assert property (!cap_evt[i] && !wr_hold |=> $stable(hold_ff[i]))
            else $error("hold changed without its own edge");
    end

    // Compare/reload, control and enable registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_ff <= CNT_RST;
            ctrl_ff <= CTRL_RST;
            ien_ff <= FLAG_RST;
        end else if (do_wr) begin
            if (hit(waddr_ff, OFF_CMP)) begin
                cmp_ff <= CNT_W'(merge({8'h00, cmp_ff}, wdata_ff, wstrb_ff));
            end
            if (hit(waddr_ff, OFF_CTRL)) begin
                ctrl_ff <= CTRL_W'(merge({17'h0_0000, ctrl_ff}, wdata_ff, wstrb_ff));
            end
            if (hit(waddr_ff, OFF_IEN)) begin
                ien_ff <= FLAG_W'(merge({26'h000_0000, ien_ff}, wdata_ff, wstrb_ff)) & FLAG_MASK;
            end
        end
    end

    // Sticky flags: a set in the clearing cycle survives
    always_comb begin
        flag_set = '0;
        flag_set[ST_EDGE +: NCH] = cap_evt;
        flag_set[ST_MATCH] = match_evt;
        flag_set[ST_OVF] = ovf_evt;
        flag_clr = '0;
        if (do_wr && (hit(waddr_ff, OFF_STAT) || hit(waddr_ff, OFF_ICLR))) begin
            flag_clr = wdata_ff[FLAG_W-1:0] & {FLAG_W{wstrb_ff[0]}} & FLAG_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_ff <= FLAG_RST;
        end else begin
            flag_ff <= (flag_ff & ~flag_clr) | flag_set;
        end
    end

    // Registered interrupt level, one cycle behind the flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(flag_ff & ien_ff);
        end
    end

    assign irq = irq_ff;

    // Checks on the counter, flags and write response
    sequence s_quiet;
        !wr_cnt && !reload_evt && !clear_edge && !clear_match;
    endsequence

    sequence s_both_got;
        aw_got_ff && w_got_ff && !bvalid_ff;
    endsequence

    a_cnt_upper: assert property (rvalid_ff && $rose(rvalid_ff) && hit($past(s_axi_araddr), OFF_CNT)
                                  |-> rdata_ff == {8'h00, $past(cnt_ff)})
        else $error("counter upper bits not zero");
    a_no_tick_hold: assert property (!tk.tick && !wr_cnt && !reload_evt && !clear_edge && !clear_match
                                     |=> $stable(cnt_ff))
        else $error("counter moved without a tick");
    a_run_count: assert property (run && tk.tick && cnt_ff != CNT_MAX ##0 s_quiet
                                  |=> cnt_ff == $past(cnt_ff) + CNT_ONE)
        else $error("counter did not count on a tick");
    a_stop_hold: assert property (!run ##0 s_quiet |=> $stable(cnt_ff))
        else $error("counter moved while stopped");
    a_match_flag: assert property (cmp_en && inc && cnt_ff + CNT_ONE == cmp_ff
                                   |=> flag_ff[ST_MATCH] && cnt_ff != $past(cnt_ff))
        else $error("match not flagged");
    a_match_off: assert property (!cmp_en && !(do_wr) && !flag_ff[ST_MATCH]
                                  |=> !flag_ff[ST_MATCH])
        else $error("match flagged with compare off");
    a_reload: assert property (reload_evt && !wr_cnt |=> cnt_ff == $past(cmp_ff))
        else $error("reload did not load compare value");
    a_no_clear_in_reload: assert property (rld_en && clr_edge_en && |cap_evt && !inc && !wr_cnt
                                           && !reload_evt |=> $stable(cnt_ff))
        else $error("edge cleared counter in reload mode");
    a_flag_sticky: assert property (flag_ff[ST_OVF] && !flag_clr[ST_OVF] |=> flag_ff[ST_OVF])
        else $error("flag dropped without a clear");
    a_wrap_ovf: assert property (ovf_evt ##0 s_quiet |=> cnt_ff == CNT_RST && flag_ff[ST_OVF])
        else $error("overflow did not wrap and flag");
    a_write_resp: assert property (s_both_got |=> bvalid_ff ##1 !aw_got_ff)
        else $error("write response missing");
endmodule
`default_nettype wire
